// ---- mode_timing_map.vh ----
`ifndef MODE_TIMING_MAP_VH
`define MODE_TIMING_MAP_VH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_OUTPUT_FEATURE 5'h07
`define ADDR_INPUT_FORMAT   5'h08
`define ADDR_LUMA_LIMIT     5'h09
`define ADDR_TIMING_MODE    5'h0a
`define ADDR_SYNC_SHAPE     5'h0b
`define REG_RESET           8'h00
// ----------------------------------------------------------------------
// output_feature_enable fields
// ----------------------------------------------------------------------
`define BIT_HUE_EN          2
`define BIT_BRIGHT_EN       3
`define BIT_SHARP_EN        4
`define BIT_SYNC_SEL        5
`define BIT_PIN_DIR         6
`define BIT_CLAMP_SEL       7
// ----------------------------------------------------------------------
// input_format_config fields
// ----------------------------------------------------------------------
`define BIT_PROG_EN         0
`define BIT_DBUF_EN         2
`define BIT_WIDE_EN         3
`define BIT_TEN_EN          4
`define BIT_DNR_EN          5
`define BIT_GAMMA_EN        6
`define BIT_GAMMA_SEL       7
// ----------------------------------------------------------------------
// luma_limit_burst_config fields
// ----------------------------------------------------------------------
`define LIM_LO              0
`define LIM_HI              1
`define BIT_BB_A            2
`define BIT_BB_B            3
`define CDLY_LO             5
`define CDLY_HI             7
// ----------------------------------------------------------------------
// timing_mode_control fields
// ----------------------------------------------------------------------
`define BIT_MASTER          0
`define TMODE_LO            1
`define TMODE_HI            2
`define BIT_BLANK_SEL       3
`define LDLY_LO             4
`define LDLY_HI             5
`define BIT_MIN_LUMA        6
`define BIT_TRESET          7
// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define FILT_EXTENDED       3'h4
`define PORT_8              2'h0
`define PORT_10             2'h1
`define PORT_16             2'h2
`define PORT_20             2'h3
`define LIM_OFF             2'h0
`define LIM_N1P5            2'h1
`define LIM_N6              2'h2
`define LIM_N11             2'h3
`define LUMA_FLOOR_SYNC     2'h0
`define LUMA_FLOOR_7IRE     2'h1
`define PIN_MODE_TTX_IN     2'h0
`define PIN_MODE_VSYNC_OUT  2'h1
`define PIN_MODE_CLAMP_OUT  2'h2
`define LDLY_STEP           3'h2
`define TMODE_EDGE          2'h1
`define TMODE_VWIDTH        2'h2
// ----------------------------------------------------------------------
// sync_shape_control fields
// ----------------------------------------------------------------------
`define HSW_LO              0
`define HSW_HI              1
`define HVD_LO              2
`define HVD_HI              3
`define VSE_LO              4
`define VSE_HI              5
`define PIX_LO              6
`define PIX_HI              7
`endif

// ---- mode_timing_regs.v ----
`include "mode_timing_map.vh"

// Behaviour
// - hue enable applies programmed hue rotation
// - brightness enable adds set-up level
// - sharpness only with extended luma filter
// - sync pin carries composite or horizontal sync
// - shared pin output or teletext input
// - output carries clamp or vertical sync
// - progressive input, never with 16-bit port
// - port width from wide and ten-bit
// - double buffering, not in master mode
// - noise reduction stage or bypass
// - gamma enable, curve A or B
// - undershoot limit only at 4x oversampling
// - 2x or RGB no-sync forces undershoot limit off
// - black burst enables drive luma DAC
// - chroma delay up to eight cycles
// - master/slave and timing mode select
// - blank select, high pin disables external
// - luma delay zero to six cycles
// - min luma clamps 7 IRE below blank
// - low-high-low toggle resets timing counters
// - hsync width, offset, vsync edge/width
// - hsync to pixel adjust, both modes
module mode_timing_regs (
    input  wire       clock,
    input  wire       rst_b,
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire [4:0] addr,
    input  wire [7:0] wr_data,
    output reg  [7:0] rd_data,
    output reg        rd_hit,
    input  wire       field_start,
    input  wire       oversample_select,
    input  wire       rgb_no_sync,
    input  wire [2:0] luma_filter_select,
    input  wire       blank_pin_high,
    output reg        hue_adjust_enable,
    output reg        brightness_enable,
    output reg        sharpness_active,
    output reg        sync_output_select,
    output reg        shared_pin_direction,
    output reg  [1:0] shared_pin_mode,
    output reg        progressive_input_enable,
    output reg  [1:0] port_format,
    output reg        double_buffer_active,
    output reg        noise_reduction_enable,
    output reg        gamma_enable,
    output reg        gamma_curve_select,
    output reg  [1:0] undershoot_limit_level,
    output reg  [1:0] luma_floor_mode,
    output reg        black_burst_enable_a,
    output reg        black_burst_enable_b,
    output reg  [2:0] chroma_delay_field,
    output reg        master_slave_select,
    output reg  [1:0] timing_mode_field,
    output reg        external_blank_enable,
    output reg  [2:0] luma_delay_cycles,
    output reg        timing_counter_reset,
    output reg  [1:0] hsync_width_field,
    output reg  [1:0] hsync_vsync_delay_field,
    output reg  [1:0] vsync_edge_offset,
    output reg  [1:0] vsync_width,
    output reg  [1:0] hsync_pixel_adjust_field
);

// ----------------------------------------------------------------------
// register storage
// ----------------------------------------------------------------------
reg  [7:0] output_feature_enable_r;
reg  [7:0] input_format_config_r;
reg  [7:0] luma_limit_burst_config_r;
reg  [7:0] timing_mode_control_r;
reg  [7:0] sync_shape_control_r;
reg        treset_armed_r;
reg        hue_act_r;
reg        gamma_sel_act_r;
reg        blank_meta_r;
reg        blank_sync_r;

// ----------------------------------------------------------------------
// blank pin synchroniser
// ----------------------------------------------------------------------
// the pin is asynchronous to this clock; only the second stage is read
always @(posedge clock) begin
    if (!rst_b) begin
        blank_meta_r <= 1'b0;
        blank_sync_r <= 1'b0;
    end else begin
        blank_meta_r <= blank_pin_high;
        blank_sync_r <= blank_meta_r;
    end
end

wire wr_feat = wr_en && (addr == `ADDR_OUTPUT_FEATURE);
wire wr_fmt  = wr_en && (addr == `ADDR_INPUT_FORMAT);
wire wr_tr0  = wr_en && (addr == `ADDR_TIMING_MODE);

// double buffering only in slave timing
wire dbuf_on = input_format_config_r[`BIT_DBUF_EN]
               && !timing_mode_control_r[`BIT_MASTER];

always @(posedge clock) begin
    if (!rst_b) begin
        output_feature_enable_r   <= `REG_RESET;
        input_format_config_r     <= `REG_RESET;
        luma_limit_burst_config_r <= `REG_RESET;
        timing_mode_control_r     <= `REG_RESET;
        sync_shape_control_r      <= `REG_RESET;
    end else if (wr_en) begin
        case (addr)
            `ADDR_OUTPUT_FEATURE: output_feature_enable_r   <= wr_data;
            `ADDR_INPUT_FORMAT:   input_format_config_r     <= wr_data;
            `ADDR_LUMA_LIMIT:     luma_limit_burst_config_r <= wr_data;
            `ADDR_TIMING_MODE:    timing_mode_control_r     <= wr_data;
            `ADDR_SYNC_SHAPE:     sync_shape_control_r      <= wr_data;
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------------
// shadowed settings: hue enable and gamma curve select
// ----------------------------------------------------------------------
// the shadow is the register itself; with double buffering on, the active copy moves only at field start
// so a mid-field write never tears the picture
always @(posedge clock) begin
    if (!rst_b) begin
        hue_act_r       <= 1'b0;
        gamma_sel_act_r <= 1'b0;
    end else if (!dbuf_on || field_start) begin
        hue_act_r       <= output_feature_enable_r[`BIT_HUE_EN];
        gamma_sel_act_r <= input_format_config_r[`BIT_GAMMA_SEL];
    end
end

// ----------------------------------------------------------------------
// timing counter reset sequence
// ----------------------------------------------------------------------
// pulse on the falling write after a high write: low, high, low
always @(posedge clock) begin
    if (!rst_b) begin
        treset_armed_r       <= 1'b0;
        timing_counter_reset <= 1'b0;
    end else begin
        timing_counter_reset <= 1'b0;
        if (wr_tr0) begin
            if (wr_data[`BIT_TRESET] && !timing_mode_control_r[`BIT_TRESET])
                treset_armed_r <= 1'b1;
            if (!wr_data[`BIT_TRESET] && treset_armed_r) begin
                treset_armed_r       <= 1'b0;
                timing_counter_reset <= 1'b1;
            end
        end
    end
end

// ----------------------------------------------------------------------
// read back
// ----------------------------------------------------------------------
always @(posedge clock) begin
    if (!rst_b) begin
        rd_data <= `REG_RESET;
        rd_hit  <= 1'b0;
    end else begin
        rd_hit  <= 1'b0;
        rd_data <= `REG_RESET;
        if (rd_en) begin
            rd_hit <= 1'b1;
            case (addr)
                `ADDR_OUTPUT_FEATURE: rd_data <= output_feature_enable_r;
                `ADDR_INPUT_FORMAT:   rd_data <= input_format_config_r;
                `ADDR_LUMA_LIMIT:     rd_data <= luma_limit_burst_config_r;
                `ADDR_TIMING_MODE:    rd_data <= timing_mode_control_r;
                `ADDR_SYNC_SHAPE:     rd_data <= sync_shape_control_r;
                default:              rd_hit  <= 1'b0;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// decoded controls
// ----------------------------------------------------------------------
reg  [1:0] port_nxt;
reg  [1:0] pin_nxt;
reg  [1:0] floor_nxt;
reg  [1:0] lim_nxt;

always @* begin
    port_nxt = {input_format_config_r[`BIT_WIDE_EN],
                input_format_config_r[`BIT_TEN_EN]};
    // progressive mode cannot share the 16-bit port; fall back to 8-bit
    if (input_format_config_r[`BIT_PROG_EN] && port_nxt == `PORT_16)
        port_nxt = `PORT_8;
    if (!output_feature_enable_r[`BIT_PIN_DIR])
        pin_nxt = `PIN_MODE_TTX_IN;
    else if (output_feature_enable_r[`BIT_CLAMP_SEL])
        pin_nxt = `PIN_MODE_CLAMP_OUT;
    else
        pin_nxt = `PIN_MODE_VSYNC_OUT;
    lim_nxt = luma_limit_burst_config_r[`LIM_HI:`LIM_LO];
    floor_nxt = timing_mode_control_r[`BIT_MIN_LUMA] ? `LUMA_FLOOR_7IRE
                                                     : `LUMA_FLOOR_SYNC;
    if (!oversample_select || rgb_no_sync)
        lim_nxt = `LIM_OFF;
end

always @(posedge clock) begin
    if (!rst_b) begin
        hue_adjust_enable        <= 1'b0;
        brightness_enable        <= 1'b0;
        sharpness_active         <= 1'b0;
        sync_output_select       <= 1'b0;
        shared_pin_direction     <= 1'b0;
        shared_pin_mode          <= `PIN_MODE_TTX_IN;
        progressive_input_enable <= 1'b0;
        port_format              <= `PORT_8;
        double_buffer_active     <= 1'b0;
        noise_reduction_enable   <= 1'b0;
        gamma_enable             <= 1'b0;
        gamma_curve_select       <= 1'b0;
        undershoot_limit_level   <= `LIM_OFF;
        luma_floor_mode          <= `LUMA_FLOOR_SYNC;
        black_burst_enable_a     <= 1'b0;
        black_burst_enable_b     <= 1'b0;
        chroma_delay_field       <= 3'h0;
        master_slave_select      <= 1'b0;
        timing_mode_field        <= 2'h0;
        external_blank_enable    <= 1'b0;
        luma_delay_cycles        <= 3'h0;
        hsync_width_field        <= 2'h0;
        hsync_vsync_delay_field  <= 2'h0;
        vsync_edge_offset        <= 2'h0;
        vsync_width              <= 2'h0;
        hsync_pixel_adjust_field <= 2'h0;
    end else begin
        hue_adjust_enable        <= hue_act_r;
        brightness_enable        <= output_feature_enable_r[`BIT_BRIGHT_EN];
        sharpness_active         <= output_feature_enable_r[`BIT_SHARP_EN]
                                    && (luma_filter_select == `FILT_EXTENDED);
        sync_output_select       <= output_feature_enable_r[`BIT_SYNC_SEL];
        shared_pin_direction     <= output_feature_enable_r[`BIT_PIN_DIR];
        shared_pin_mode          <= pin_nxt;
        progressive_input_enable <= input_format_config_r[`BIT_PROG_EN];
        port_format              <= port_nxt;
        double_buffer_active     <= dbuf_on;
        noise_reduction_enable   <= input_format_config_r[`BIT_DNR_EN];
        gamma_enable             <= input_format_config_r[`BIT_GAMMA_EN];
        gamma_curve_select       <= gamma_sel_act_r;
        undershoot_limit_level   <= lim_nxt;
        luma_floor_mode          <= floor_nxt;
        black_burst_enable_a     <= luma_limit_burst_config_r[`BIT_BB_A];
        black_burst_enable_b     <= luma_limit_burst_config_r[`BIT_BB_B];
        chroma_delay_field       <= luma_limit_burst_config_r[`CDLY_HI:`CDLY_LO];
        master_slave_select      <= timing_mode_control_r[`BIT_MASTER];
        timing_mode_field        <= timing_mode_control_r[`TMODE_HI:`TMODE_LO];
        // a high pin overrides the register and forces internal blanking
        external_blank_enable    <= timing_mode_control_r[`BIT_BLANK_SEL]
                                    && !blank_sync_r;
        // two-bit code in steps of two cycles gives 0..6
        luma_delay_cycles        <= {1'b0, timing_mode_control_r[`LDLY_HI:`LDLY_LO]}
                                    * `LDLY_STEP;
        hsync_width_field        <= sync_shape_control_r[`HSW_HI:`HSW_LO];
        hsync_vsync_delay_field  <= sync_shape_control_r[`HVD_HI:`HVD_LO];
        vsync_edge_offset        <= (timing_mode_control_r[`TMODE_HI:`TMODE_LO] == `TMODE_EDGE)
                                    ? sync_shape_control_r[`VSE_HI:`VSE_LO] : 2'h0;
        vsync_width              <= (timing_mode_control_r[`TMODE_HI:`TMODE_LO] == `TMODE_VWIDTH)
                                    ? sync_shape_control_r[`VSE_HI:`VSE_LO] : 2'h0;
        hsync_pixel_adjust_field <= sync_shape_control_r[`PIX_HI:`PIX_LO];
    end
end

endmodule // mode_timing_regs

// ---- mode_timing_regs_chk.sv ----
`include "mode_timing_map.vh"
// ----------------------------------------
// port checks for the mode and timing bank
// ----------------------------------------
module mode_timing_regs_chk (
    input wire       clock,
    input wire       rst_b,
    input wire       wr_en,
    input wire       rd_en,
    input wire [4:0] addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data,
    input wire       rd_hit,
    input wire [2:0] luma_filter_select,
    input wire       oversample_select,
    input wire       rgb_no_sync,
    input wire       sharpness_active,
    input wire       sync_output_select,
    input wire [1:0] shared_pin_mode,
    input wire       progressive_input_enable,
    input wire [1:0] port_format,
    input wire [1:0] undershoot_limit_level,
    input wire       master_slave_select,
    input wire [2:0] luma_delay_cycles,
    input wire       timing_counter_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // write data delayed to line up with the two-edge output latency
    reg  [7:0] wd1_r;
    reg  [7:0] wd2_r;
    wire       mapped = addr >= `ADDR_OUTPUT_FEATURE && addr <= `ADDR_SYNC_SHAPE;
    wire       wr_tm  = wr_en && addr == `ADDR_TIMING_MODE;
    wire       wr_of  = wr_en && addr == `ADDR_OUTPUT_FEATURE;
    always @(posedge clock) begin
        wd1_r <= wr_data;
        wd2_r <= wd1_r;
    end
    read_miss_a: assert property (rd_en && !mapped |=> !rd_hit && rd_data == 8'h00)
        else $error("unmapped read returned a hit or data");
    read_hit_a: assert property (rd_en && mapped |=> rd_hit)
        else $error("mapped read gave no hit");
    master_sel_a: assert property (wr_tm |-> ##2 master_slave_select == wd2_r[0])
        else $error("master select not taken from write");
    luma_delay_a: assert property (wr_tm |-> ##2 luma_delay_cycles == {wd2_r[5:4], 1'b0})
        else $error("luma delay not twice the code");
    sync_sel_a: assert property (wr_of |-> ##2 sync_output_select == wd2_r[5])
        else $error("sync pin select wrong");
    pin_mode_a: assert property (wr_of |-> ##2
        shared_pin_mode == (wd2_r[6] ? (wd2_r[7] ? 2'h2 : 2'h1) : 2'h0))
        else $error("shared pin mode wrong");
    sharp_gate_a: assert property (sharpness_active |->
        $past(luma_filter_select) == `FILT_EXTENDED)
        else $error("sharpness without extended filter");
    prog_port_a: assert property (progressive_input_enable |-> port_format != `PORT_16)
        else $error("progressive with 16-bit port");
    limit_gate_a: assert property (undershoot_limit_level != 2'h0 |->
        $past(oversample_select) && !$past(rgb_no_sync))
        else $error("undershoot limit outside 4x mode");
    treset_pulse_a: assert property (timing_counter_reset |=> !timing_counter_reset)
        else $error("timing reset longer than one cycle");
    cover property (timing_counter_reset);
    cover property (rd_en && !mapped);
    cover property (sharpness_active);
endmodule // mode_timing_regs_chk

bind mode_timing_regs mode_timing_regs_chk chk (.*);

// ---- mode_timing_regs_bench.sv ----
`include "mode_timing_map.vh"
module mode_timing_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wr_data = 8'h00;
    logic       field_start = 1'b0;
    logic       oversample_select = 1'b0;
    logic       rgb_no_sync = 1'b0;
    logic [2:0] luma_filter_select = 3'h0;
    logic       blank_pin_high = 1'b0;
    wire  [7:0] rd_data;
    wire        rd_hit, hue_adjust_enable, brightness_enable, sharpness_active;
    wire        sync_output_select, shared_pin_direction, progressive_input_enable;
    wire        double_buffer_active, noise_reduction_enable, gamma_enable;
    wire        gamma_curve_select, black_burst_enable_a, black_burst_enable_b;
    wire        master_slave_select, external_blank_enable, timing_counter_reset;
    wire  [1:0] shared_pin_mode, port_format, undershoot_limit_level, luma_floor_mode;
    wire  [1:0] timing_mode_field, hsync_width_field, hsync_vsync_delay_field;
    wire  [1:0] vsync_edge_offset, vsync_width, hsync_pixel_adjust_field;
    wire  [2:0] chroma_delay_field, luma_delay_cycles;
    int         seed = 32'hc1504b7e;
    int         n_mismatch = 0;
    int         compares = 0;
    int         cycles = 0;
    logic [7:0] mdl [0:31];
    logic [8:0] exp_q [$];
    logic       rd_seen = 1'b0;
    mode_timing_regs dut (.*);
    always #10 clock = ~clock;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [8:0] exp_rd(input logic [4:0] a);
        return (a >= 5'h07 && a <= 5'h0b) ? {1'b1, mdl[a]} : 9'h000;
    endfunction
    // strobes stay up until the caller goes idle, so no signal changes twice per step
    task automatic access(input logic w, input logic r, input logic [4:0] a,
                          input logic [7:0] d);
        wr_en = w;
        rd_en = r;
        addr = a;
        wr_data = d;
        if (w && a >= 5'h07 && a <= 5'h0b) mdl[a] = d;
        if (r) exp_q.push_back(exp_rd(a));
        @(posedge clock);
        #2;
    endtask
    task automatic idle(input int n);
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (n) @(posedge clock);
        #2;
    endtask
    // read results land one cycle after the read is taken
    always @(posedge clock) begin
        if (rd_seen) check("read", exp_q.pop_front(), {rd_hit, rd_data});
        rd_seen <= rd_en;
    end
    always @(posedge clock) begin
        #2;
        {oversample_select, rgb_no_sync, luma_filter_select} = 5'($random(seed));
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin : main
        logic [4:0] a;
        int         n;
        for (int i = 0; i < 32; i++) mdl[i] = 8'h00;
        repeat (20) @(posedge clock);
        #2;
        rst_b = 1'b1;
        for (int i = 0; i < 32; i++) access(1'b0, 1'b1, 5'(i), 8'h00);
        repeat (80) begin
            a = 5'h05 + 5'({$random(seed)} % 8);
            access(1'b1, 1'b0, a, 8'($random(seed)));
            access(1'b0, 1'b1, a, 8'h00);
        end
        for (int p = 0; p < 4; p++) begin
            access(1'b1, 1'b0, `ADDR_INPUT_FORMAT, {3'h0, p[0], p[1], 3'h0});
            idle(2);
            check("port_format", 9'(p), {7'h00, port_format});
        end
        access(1'b1, 1'b0, `ADDR_INPUT_FORMAT, 8'h09);
        idle(2);
        check("prog_port", 9'(`PORT_8), {7'h00, port_format});
        access(1'b1, 1'b0, `ADDR_TIMING_MODE, 8'h00);
        access(1'b1, 1'b0, `ADDR_TIMING_MODE, 8'h80);
        access(1'b1, 1'b0, `ADDR_TIMING_MODE, 8'h00);
        n = 0;
        repeat (4) begin
            n += int'(timing_counter_reset === 1'b1);
            idle(1);
        end
        check("treset_pulses", 9'h001, 9'(n));
        access(1'b1, 1'b0, `ADDR_OUTPUT_FEATURE, 8'h00);
        access(1'b1, 1'b0, `ADDR_INPUT_FORMAT, 8'h04);
        idle(3);
        check("dbuf_slave", 9'h001, {8'h00, double_buffer_active});
        access(1'b1, 1'b0, `ADDR_OUTPUT_FEATURE, 8'h04);
        idle(4);
        check("hue_held", 9'h000, {8'h00, hue_adjust_enable});
        field_start = 1'b1;
        @(posedge clock);
        #2;
        field_start = 1'b0;
        idle(3);
        check("hue_field", 9'h001, {8'h00, hue_adjust_enable});
        access(1'b1, 1'b0, `ADDR_TIMING_MODE, 8'h01);
        idle(3);
        check("dbuf_master", 9'h000, {8'h00, double_buffer_active});
        access(1'b1, 1'b0, `ADDR_OUTPUT_FEATURE, 8'he8);
        access(1'b1, 1'b0, `ADDR_INPUT_FORMAT, 8'he0);
        access(1'b1, 1'b0, `ADDR_LUMA_LIMIT, 8'hac);
        access(1'b1, 1'b0, `ADDR_TIMING_MODE, 8'h5c);
        access(1'b1, 1'b0, `ADDR_SYNC_SHAPE, 8'he7);
        blank_pin_high = 1'b1;
        idle(5);
        check("bright_sync", 9'h003, {7'h00, brightness_enable, sync_output_select});
        check("pin", 9'h006, {6'h00, shared_pin_direction, shared_pin_mode});
        check("dnr_gamma", 9'h007,
              {6'h00, noise_reduction_enable, gamma_enable, gamma_curve_select});
        check("burst_cdly", 9'h01d,
              {4'h0, black_burst_enable_a, black_burst_enable_b, chroma_delay_field});
        check("tmode", 9'h002, {6'h00, master_slave_select, timing_mode_field});
        check("floor_ldly", 9'h00a, {4'h0, luma_floor_mode, luma_delay_cycles});
        check("blank_pin", 9'h000, {8'h00, external_blank_enable});
        check("tr1_fields", 9'h037,
              {3'h0, hsync_width_field, hsync_vsync_delay_field, hsync_pixel_adjust_field});
        check("tr1_mode2", 9'h002, {5'h00, vsync_edge_offset, vsync_width});
        blank_pin_high = 1'b0;
        access(1'b1, 1'b0, `ADDR_TIMING_MODE, 8'h5a);
        idle(5);
        check("blank_ext", 9'h001, {8'h00, external_blank_enable});
        check("tr1_mode1", 9'h008, {5'h00, vsync_edge_offset, vsync_width});
        idle(2);
        conclude();
    end
endmodule // mode_timing_regs_bench
